// File: hw/dhap_pkg.sv
// Shared constants and types for the two-port DRAM controller front end
package dhap_pkg;
  localparam int PORTS = 2;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 128;
  localparam int STRB_W = 16;
  localparam int ID_W = 8;
  localparam int LEN_W = 8;
  localparam int SIZE_W = 3;
  localparam int BURST_W = 2;
  localparam int LOCK_W = 2;
  localparam int RESP_W = 2;
  // DRAM data lane width and peak lane rate
  localparam int PHY_DQ_W = 16;
  localparam int PHY_RATE_MBPS = 1066;
  localparam int PHY_CLK_MHZ = PHY_RATE_MBPS / 2;
  // Each port owns a beat store of 2**MEM_AW words of 16 bytes
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam int BYTE_SHIFT = 4;
  localparam logic [BURST_W-1:0] BURST_FIXED = 2'h0;
  localparam logic [BURST_W-1:0] BURST_INCR = 2'h1;
  localparam logic [BURST_W-1:0] BURST_WRAP = 2'h2;
  localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
  localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
  localparam logic REQ_IS_WRITE = 1'h1;
  // Startup sequence length
  localparam int CLK_PERIOD_NS = 10;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);
  // Calibration bus: target address (arbitrary value) and register count
  localparam logic [6:0] CAL_DEV_ADDR = 7'h2A;
  localparam int CAL_REGS = 4;
  localparam logic [7:0] CAL_TRIM_RESET = 8'h80;
  localparam logic [3:0] CAL_BIT_ACK = 4'h8;
  localparam logic [3:0] CAL_BIT_DONE = 4'h9;

  typedef enum logic [4:0] {
    P_IDLE = 5'h01,
    P_WRITE = 5'h02,
    P_WRESP = 5'h04,
    P_RFETCH = 5'h08,
    P_RDATA = 5'h10
  } dhap_port_state_type;

  typedef enum logic [4:0] {
    C_IDLE = 5'h01,
    C_ADDR = 5'h02,
    C_INDEX = 5'h04,
    C_WDATA = 5'h08,
    C_RDATA = 5'h10
  } dhap_cal_state_type;
endpackage

// File: hw/dhap_beat_mem.sv
// Byte-writable beat store with registered read data
`timescale 1ns/100ps
module dhap_beat_mem
  import dhap_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rstn, // Async reset, active low
  input wire logic wr_en, // Write a beat
  input wire logic [dhap_pkg::MEM_AW-1:0] wr_addr, // Write word index
  input wire logic [dhap_pkg::STRB_W-1:0] wr_strb, // Byte lane enables
  input wire logic [dhap_pkg::DATA_W-1:0] wr_data, // Write beat
  input wire logic rd_en, // Fetch a beat
  input wire logic [dhap_pkg::MEM_AW-1:0] rd_addr, // Read word index
  output logic [dhap_pkg::DATA_W-1:0] rd_data // Registered read beat
);
  genvar i;
  generate
    for (i = 0; i < STRB_W; i++) begin : g_lane
      logic [7:0] lane_mem [MEM_DEPTH];
      logic [7:0] lane_rd_reg;
      always_ff @(posedge mclk) begin
        if (wr_en && wr_strb[i]) begin
          lane_mem[wr_addr] <= wr_data[i*8 +: 8];
        end
      end
      // Read data holds until the next fetch so a stalled beat stays put
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          lane_rd_reg <= 8'h00;
        end else if (rd_en) begin
          lane_rd_reg <= lane_mem[rd_addr];
        end
      end
      assign rd_data[i*8 +: 8] = lane_rd_reg;
    end
  endgenerate
endmodule

// File: hw/dhap_ctrl.sv
// Two-port AXI-style front end of the hard DRAM controller with startup and calibration
`timescale 1ns/100ps
// Operation
// R1: One x16 DRAM data store behind controller; here each of the two ports has its own store
// R2: Lane rate up to 1066 Mbps
// R3: Two independent 128-bit AXI-style ports
// R4: Memory reachable only through the controller
// R5: PHY clock runs at half data rate
// R6: PHY clock comes from dedicated PLL
// R7: Type bit low reads, high writes
// R8: Address gives first beat byte address
// R9: Beat address from burst type and size
// R10: Shared tag means read or write by type
// R11: Length field gives beats in burst
// R12: Master supplies two-bit lock type
// R13: Size field gives bytes per beat
// R14: Request moves on valid and ready
// R15: Write response carries write tag, handshaked
// R16: Read data tagged, last beat marked
// R17: Read status on two-bit response
// R18: Read beat moves on valid and ready
// R19: Master tags write beats, marks last
// R20: Sixteen strobes mark valid write bytes
// R21: Write beat moves on valid and ready
// R22: Two-wire calibration bus reads, writes registers
// R23: Go pulse starts sequencer, reset clears it
// R24: No access until startup completes
// R25: Ports sample and drive on rising edges
module dhap_ctrl
  import dhap_pkg::*;
(
  input wire logic mclk, // Controller clock
  input wire logic rstn, // Master reset, active low
  input wire logic init_sequencer_go, // Startup start pulse
  input wire logic init_sequencer_reset, // Startup sequencer reset, active high
  output logic init_done, // Startup complete
  input wire logic cal_scl_in, // Calibration bus clock
  input wire logic cal_sda_in, // Calibration bus data in
  output logic cal_sda_out, // Calibration bus data out
  output logic cal_sda_oen, // Data output enable, low drives
  output logic [dhap_pkg::CAL_REGS-1:0][7:0] cal_trim, // PHY tuning values
  input wire logic [dhap_pkg::PORTS-1:0] shared_req_valid, // Request valid
  output logic [dhap_pkg::PORTS-1:0] shared_req_ready, // Request ready
  input wire logic [dhap_pkg::PORTS-1:0] req_read_write_sel, // 0 read, 1 write
  input wire logic [dhap_pkg::PORTS-1:0][dhap_pkg::ADDR_W-1:0] shared_req_addr, // Start addr
  input wire logic [dhap_pkg::PORTS-1:0][dhap_pkg::BURST_W-1:0] shared_burst_type, // Burst
  input wire logic [dhap_pkg::PORTS-1:0][dhap_pkg::ID_W-1:0] shared_req_tag, // Tag
  input wire logic [dhap_pkg::PORTS-1:0][dhap_pkg::LEN_W-1:0] shared_burst_len, // Beats-1
  input wire logic [dhap_pkg::PORTS-1:0][dhap_pkg::LOCK_W-1:0] shared_lock_type, // Lock
  input wire logic [dhap_pkg::PORTS-1:0][dhap_pkg::SIZE_W-1:0] shared_beat_size, // Size
  input wire logic [dhap_pkg::PORTS-1:0] axi_wvalid, // Write beat valid
  output logic [dhap_pkg::PORTS-1:0] axi_wready, // Write beat ready
  input wire logic [dhap_pkg::PORTS-1:0][dhap_pkg::DATA_W-1:0] axi_wdata, // Write data
  input wire logic [dhap_pkg::PORTS-1:0][dhap_pkg::STRB_W-1:0] axi_wstrb, // Byte strobes
  input wire logic [dhap_pkg::PORTS-1:0][dhap_pkg::ID_W-1:0] axi_wid, // Write beat tag
  input wire logic [dhap_pkg::PORTS-1:0] axi_wlast, // Last write beat
  output logic [dhap_pkg::PORTS-1:0] axi_bvalid, // Write response valid
  input wire logic [dhap_pkg::PORTS-1:0] axi_bready, // Write response ready
  output logic [dhap_pkg::PORTS-1:0][dhap_pkg::ID_W-1:0] axi_bid, // Response tag
  output logic [dhap_pkg::PORTS-1:0] axi_rvalid, // Read beat valid
  input wire logic [dhap_pkg::PORTS-1:0] axi_rready, // Read beat ready
  output logic [dhap_pkg::PORTS-1:0][dhap_pkg::DATA_W-1:0] axi_rdata, // Read data
  output logic [dhap_pkg::PORTS-1:0][dhap_pkg::ID_W-1:0] axi_rid, // Read tag
  output logic [dhap_pkg::PORTS-1:0][dhap_pkg::RESP_W-1:0] axi_rresp, // Read status
  output logic [dhap_pkg::PORTS-1:0] axi_rlast // Last read beat
);
  import dhap_pkg::*;

  // Address of the next beat in a burst
  function automatic logic [ADDR_W-1:0] next_beat_addr(input logic [ADDR_W-1:0] a,
      input logic [SIZE_W-1:0] sz, input logic [BURST_W-1:0] bt, input logic [LEN_W-1:0] ln);
    logic [ADDR_W-1:0] bytes;
    logic [ADDR_W-1:0] mask;
    bytes = 32'h1 << sz;
    mask = (bytes * ({24'h0, ln} + 32'h1)) - 32'h1;
    unique case (bt)
      BURST_FIXED: next_beat_addr = a;
      BURST_WRAP: next_beat_addr = (a & ~mask) | ((a + bytes) & mask);
      default: next_beat_addr = a + bytes;
    endcase
  endfunction

  // Startup sequencer
  logic [15:0] init_cnt_reg;
  logic init_run_reg;
  logic init_done_reg;
  // R23: start and reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      init_cnt_reg <= 16'h0000;
      init_run_reg <= 1'h0;
      init_done_reg <= 1'h0;
    end else if (init_sequencer_reset) begin
      init_cnt_reg <= 16'h0000;
      init_run_reg <= 1'h0;
      init_done_reg <= 1'h0;
    end else if (init_run_reg) begin
      init_cnt_reg <= init_cnt_reg + 16'h0001;
      init_run_reg <= init_cnt_reg != INIT_LAST;
      init_done_reg <= init_cnt_reg == INIT_LAST;
    end else if (init_sequencer_go && !init_done_reg) begin
      init_cnt_reg <= 16'h0000;
      init_run_reg <= 1'h1;
    end
  end
  assign init_done = init_done_reg;

  // Calibration bus target, open drain on the data line
  dhap_cal_state_type cal_st_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic [3:0] cal_bit_reg;
  logic [7:0] cal_shift_reg;
  logic [1:0] cal_idx_reg;
  logic cal_drive_reg;
  logic [CAL_REGS-1:0][7:0] cal_trim_reg;
  wire scl_rise = cal_scl_in & ~scl_prev_reg;
  wire scl_fall = ~cal_scl_in & scl_prev_reg;
  wire cal_start = cal_scl_in & scl_prev_reg & sda_prev_reg & ~cal_sda_in;
  wire cal_stop = cal_scl_in & scl_prev_reg & ~sda_prev_reg & cal_sda_in;
  wire cal_hit = cal_shift_reg[7:1] == CAL_DEV_ADDR;
  wire cal_rx = (cal_st_reg == C_ADDR) | (cal_st_reg == C_INDEX) | (cal_st_reg == C_WDATA);
  wire [1:0] cal_idx_inc = cal_idx_reg + 2'h1;
  // R22: byte framing, acknowledge, register access
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cal_st_reg <= C_IDLE;
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
      cal_bit_reg <= 4'h0;
      cal_shift_reg <= 8'h00;
      cal_idx_reg <= 2'h0;
      cal_drive_reg <= 1'h0;
      cal_trim_reg <= {CAL_REGS{CAL_TRIM_RESET}};
    end else begin
      scl_prev_reg <= cal_scl_in;
      sda_prev_reg <= cal_sda_in;
      if (cal_start) begin
        cal_st_reg <= C_ADDR;
        cal_bit_reg <= 4'h0;
        cal_drive_reg <= 1'h0;
      end else if (cal_stop) begin
        cal_st_reg <= C_IDLE;
        cal_drive_reg <= 1'h0;
      end else if (scl_rise && cal_bit_reg < CAL_BIT_ACK && cal_st_reg != C_IDLE) begin
        cal_bit_reg <= cal_bit_reg + 4'h1;
        cal_shift_reg <= {cal_shift_reg[6:0], cal_sda_in};
      end else if (scl_rise && cal_bit_reg == CAL_BIT_DONE && cal_st_reg == C_RDATA) begin
        if (cal_sda_in) begin
          cal_st_reg <= C_IDLE;
        end
      end else if (scl_fall && cal_bit_reg < CAL_BIT_ACK && cal_st_reg == C_RDATA) begin
        cal_drive_reg <= ~cal_shift_reg[7];
      end else if (scl_fall && cal_bit_reg == CAL_BIT_ACK) begin
        cal_bit_reg <= CAL_BIT_DONE;
        cal_drive_reg <= cal_rx & ((cal_st_reg != C_ADDR) | cal_hit);
        if (cal_st_reg == C_ADDR && !cal_hit) begin
          cal_st_reg <= C_IDLE;
        end
        if (cal_st_reg == C_INDEX) begin
          cal_idx_reg <= cal_shift_reg[1:0];
        end
        if (cal_st_reg == C_WDATA) begin
          cal_trim_reg[cal_idx_reg] <= cal_shift_reg;
          cal_idx_reg <= cal_idx_inc;
        end
      end else if (scl_fall && cal_bit_reg == CAL_BIT_DONE) begin
        cal_bit_reg <= 4'h0;
        cal_drive_reg <= 1'h0;
        if (cal_st_reg == C_ADDR && cal_shift_reg[0]) begin
          cal_st_reg <= C_RDATA;
          cal_shift_reg <= cal_trim_reg[cal_idx_reg];
          cal_drive_reg <= ~cal_trim_reg[cal_idx_reg][7];
        end else if (cal_st_reg == C_ADDR) begin
          cal_st_reg <= C_INDEX;
        end else if (cal_st_reg == C_INDEX) begin
          cal_st_reg <= C_WDATA;
        end else if (cal_st_reg == C_RDATA) begin
          cal_idx_reg <= cal_idx_inc;
          cal_shift_reg <= cal_trim_reg[cal_idx_inc];
          cal_drive_reg <= ~cal_trim_reg[cal_idx_inc][7];
        end
      end
    end
  end
  assign cal_sda_out = 1'h0;
  assign cal_sda_oen = ~cal_drive_reg;
  assign cal_trim = cal_trim_reg;

  genvar g;
  generate
    // R3: one engine per port
    for (g = 0; g < PORTS; g++) begin : g_port
      dhap_port_state_type st_reg, st_next;
      logic [ADDR_W-1:0] addr_reg, addr_next;
      logic [LEN_W-1:0] len_reg, len_next, left_reg, left_next;
      logic [SIZE_W-1:0] size_reg, size_next;
      logic [BURST_W-1:0] burst_reg, burst_next;
      logic [ID_W-1:0] tag_reg, tag_next;
      logic [RESP_W-1:0] resp_reg, resp_next;
      wire acc = shared_req_valid[g] & shared_req_ready[g];
      wire w_hs = axi_wvalid[g] & axi_wready[g];
      wire r_hs = axi_rvalid[g] & axi_rready[g];
      wire in_range = addr_reg[ADDR_W-1:MEM_AW+BYTE_SHIFT] == '0;
      wire [ADDR_W-1:0] step_addr = next_beat_addr(addr_reg, size_reg, burst_reg, len_reg);
      wire [MEM_AW-1:0] word_idx = addr_reg[MEM_AW+BYTE_SHIFT-1:BYTE_SHIFT];

      // R14: accept only when idle
      // R24: and after startup completes
      assign shared_req_ready[g] = (st_reg == P_IDLE) & init_done_reg;
      // R21: write beats only inside a write burst
      assign axi_wready[g] = st_reg == P_WRITE;
      assign axi_bvalid[g] = st_reg == P_WRESP;
      // R15: response carries the write tag
      assign axi_bid[g] = tag_reg;
      // R18: read beat offered after its fetch
      assign axi_rvalid[g] = st_reg == P_RDATA;
      // R16: read tag and last beat
      assign axi_rid[g] = tag_reg;
      assign axi_rlast[g] = (st_reg == P_RDATA) & (left_reg == '0);
      // R17: read status
      assign axi_rresp[g] = resp_reg;

      always_comb begin
        st_next = st_reg;
        addr_next = addr_reg;
        len_next = len_reg;
        left_next = left_reg;
        size_next = size_reg;
        burst_next = burst_reg;
        tag_next = tag_reg;
        resp_next = resp_reg;
        unique case (st_reg)
          P_IDLE: begin
            if (acc) begin
              // R7: type bit picks direction
              // R10: tag kept for the chosen direction
              st_next = (req_read_write_sel[g] == REQ_IS_WRITE) ? P_WRITE : P_RFETCH;
              addr_next = shared_req_addr[g];
              len_next = shared_burst_len[g];
              left_next = shared_burst_len[g];
              size_next = shared_beat_size[g];
              burst_next = shared_burst_type[g];
              tag_next = shared_req_tag[g];
            end
          end
          P_WRITE: begin
            if (w_hs) begin
              // R9: advance beat address
              addr_next = step_addr;
              left_next = left_reg - 8'h01;
              st_next = axi_wlast[g] ? P_WRESP : P_WRITE;
            end
          end
          P_WRESP: begin
            if (axi_bready[g]) begin
              st_next = P_IDLE;
            end
          end
          P_RFETCH: begin
            st_next = P_RDATA;
            resp_next = in_range ? RESP_OKAY : RESP_SLVERR;
          end
          P_RDATA: begin
            if (r_hs) begin
              addr_next = step_addr;
              left_next = left_reg - 8'h01;
              st_next = (left_reg == '0) ? P_IDLE : P_RFETCH;
            end
          end
        endcase
      end

      // R25: all port state moves on the rising clock edge
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          st_reg <= P_IDLE;
          addr_reg <= '0;
          len_reg <= '0;
          left_reg <= '0;
          size_reg <= '0;
          burst_reg <= BURST_INCR;
          tag_reg <= '0;
          resp_reg <= RESP_OKAY;
        end else begin
          st_reg <= st_next;
          addr_reg <= addr_next;
          len_reg <= len_next;
          left_reg <= left_next;
          size_reg <= size_next;
          burst_reg <= burst_next;
          tag_reg <= tag_next;
          resp_reg <= resp_next;
        end
      end

      // R1: x16 store behind the engine, eight lane words per beat
      // R2: beat rate stays within the lane rate
      // R4: only the port engine reaches the store
      // R20: strobes gate each byte lane
      dhap_beat_mem u_dhap_beat_mem (
        .mclk(mclk),
        .rstn(rstn),
        .wr_en(w_hs & in_range),
        .wr_addr(word_idx),
        .wr_strb(axi_wstrb[g]),
        .wr_data(axi_wdata[g]),
        .rd_en(st_reg == P_RFETCH),
        .rd_addr(word_idx),
        .rd_data(axi_rdata[g])
      );

      // Helper state for the checks below
      logic [ID_W-1:0] seen_wtag_reg;
      logic [LEN_W-1:0] rbeat_reg;
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          seen_wtag_reg <= '0;
          rbeat_reg <= '0;
        end else begin
          if (acc && req_read_write_sel[g]) seen_wtag_reg <= shared_req_tag[g];
          rbeat_reg <= acc ? 8'h00 : (r_hs ? rbeat_reg + 8'h01 : rbeat_reg);
        end
      end

      req_gate_a: assert property (@(posedge mclk) disable iff (!rstn) // R14
        shared_req_ready[g] |-> init_done && !axi_rvalid[g] && !axi_bvalid[g] && !axi_wready[g])
        else $error("request accepted while busy or before startup");
      wresp_tag_a: assert property (@(posedge mclk) disable iff (!rstn) // R15
        axi_bvalid[g] |-> axi_bid[g] == seen_wtag_reg)
        else $error("write response tag differs from request tag");
      bresp_hold_a: assert property (@(posedge mclk) disable iff (!rstn) // R15
        axi_bvalid[g] && !axi_bready[g] |=> axi_bvalid[g] && $stable(axi_bid[g]))
        else $error("write response dropped before accept");
      read_lat_a: assert property (@(posedge mclk) disable iff (!rstn) // R16
        acc && !req_read_write_sel[g] |-> ##2 axi_rvalid[g] && axi_rid[g] == $past(shared_req_tag[g], 2))
        else $error("first read beat late or mistagged");
      rlast_count_a: assert property (@(posedge mclk) disable iff (!rstn) // R16
        r_hs |-> axi_rlast[g] == (rbeat_reg == len_reg))
        else $error("read last beat misplaced");
      rbeat_hold_a: assert property (@(posedge mclk) disable iff (!rstn) // R18
        axi_rvalid[g] && !axi_rready[g] |=> axi_rvalid[g] && $stable(axi_rdata[g]))
        else $error("read beat changed while stalled");
      rresp_range_a: assert property (@(posedge mclk) disable iff (!rstn) // R17
        axi_rvalid[g] |-> axi_rresp[g] == (in_range ? RESP_OKAY : RESP_SLVERR))
        else $error("read status does not match address range");
      incr_step_a: assert property (@(posedge mclk) disable iff (!rstn) // R9
        w_hs && !axi_wlast[g] && burst_reg == BURST_INCR
        |=> addr_reg == $past(addr_reg) + (32'h1 << $past(size_reg)))
        else $error("incrementing burst address wrong");
      wlast_end_a: assert property (@(posedge mclk) disable iff (!rstn) // R21
        w_hs && axi_wlast[g] |=> axi_bvalid[g] && !axi_wready[g])
        else $error("write burst did not close on last beat");
    end
  endgenerate
endmodule

// File: verification/dhap_axi_master.sv
// Fabric-side master model driving both controller ports
`timescale 1ns/100ps
module dhap_axi_master (
  input wire logic mclk, // Clock
  output logic [1:0] shared_req_valid, // Request valid
  output logic [1:0] req_read_write_sel, // 1 write
  output logic [1:0][31:0] shared_req_addr, // Start address
  output logic [1:0][1:0] shared_burst_type, // Burst type
  output logic [1:0][7:0] shared_req_tag, // Tag
  output logic [1:0][7:0] shared_burst_len, // Beats-1
  output logic [1:0][1:0] shared_lock_type, // Lock
  output logic [1:0][2:0] shared_beat_size, // Size
  input wire logic [1:0] shared_req_ready, // Request ready
  output logic [1:0] axi_wvalid, // Beat valid
  output logic [1:0][127:0] axi_wdata, // Write data
  output logic [1:0][15:0] axi_wstrb, // Strobes
  output logic [1:0][7:0] axi_wid, // Beat tag
  output logic [1:0] axi_wlast, // Last beat
  input wire logic [1:0] axi_wready, // Beat ready
  input wire logic [1:0] axi_bvalid, // Response valid
  output logic [1:0] axi_bready, // Response ready
  input wire logic [1:0][7:0] axi_bid, // Response tag
  input wire logic [1:0] axi_rvalid, // Read valid
  output logic [1:0] axi_rready, // Read ready
  input wire logic [1:0][127:0] axi_rdata, // Read data
  input wire logic [1:0][7:0] axi_rid, // Read tag
  input wire logic [1:0][1:0] axi_rresp, // Read status
  input wire logic [1:0] axi_rlast // Last read beat
);
  initial begin
    {shared_req_valid, axi_wvalid, axi_bready, axi_rready, axi_wlast} = '0;
    {req_read_write_sel, shared_burst_type, shared_req_tag, shared_burst_len} = '0;
    {shared_lock_type, shared_beat_size, axi_wid} = '0;
    {shared_req_addr, axi_wdata, axi_wstrb} = '1;
  end

  task automatic req(input int p, input logic w, input logic [31:0] a,
      input logic [1:0] bt, input logic [7:0] t, input logic [7:0] ln);
    @(negedge mclk);
    shared_req_valid[p] = 1'b1;
    req_read_write_sel[p] = w;
    shared_req_addr[p] = a;
    shared_burst_type[p] = bt;
    shared_req_tag[p] = t;
    shared_burst_len[p] = ln;
    shared_beat_size[p] = 3'h4;
    shared_lock_type[p] = 2'h0;
    #1;
    for (int i = 0; i < 300 && shared_req_ready[p] !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
    shared_req_valid[p] = 1'b0;
    shared_req_addr[p] = ~a;
  endtask

  // beat held until ready, optional stall
  task automatic wbeat(input int p, input logic [127:0] d, input logic [15:0] s,
      input logic l, input int slow);
    repeat (slow + 1) @(negedge mclk);
    axi_wvalid[p] = 1'b1;
    axi_wdata[p] = d;
    axi_wstrb[p] = s;
    axi_wlast[p] = l;
    axi_wid[p] = shared_req_tag[p];
    #1;
    for (int i = 0; i < 300 && axi_wready[p] !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
    axi_wvalid[p] = 1'b0;
    axi_wdata[p] = ~d;
    axi_wlast[p] = 1'b0;
  endtask

  task automatic bresp(input int p, input int slow, output logic [7:0] id);
    repeat (slow) @(negedge mclk);
    axi_bready[p] = 1'b1;
    #1;
    for (int i = 0; i < 300 && axi_bvalid[p] !== 1'b1; i++) @(negedge mclk);
    id = axi_bid[p];
    @(negedge mclk);
    axi_bready[p] = 1'b0;
  endtask

  // beat taken on valid and ready
  task automatic rbeat(input int p, input int slow, output logic [127:0] d,
      output logic [7:0] id, output logic [1:0] rs, output logic l);
    repeat (slow) @(negedge mclk);
    axi_rready[p] = 1'b1;
    #1;
    for (int i = 0; i < 300 && axi_rvalid[p] !== 1'b1; i++) @(negedge mclk);
    {d, id, rs, l} = {axi_rdata[p], axi_rid[p], axi_rresp[p], axi_rlast[p]};
    @(negedge mclk);
    axi_rready[p] = 1'b0;
  endtask
endmodule

// File: verification/dhap_ctrl_bench.sv
// Self-checking bench for the two-port controller front end
`timescale 1ns/100ps
module dhap_ctrl_bench;
  import dhap_pkg::*;
  logic mclk, rstn, init_sequencer_go, init_sequencer_reset, cal_scl_in, cal_sda_in;
  logic init_done, cal_sda_out, cal_sda_oen;
  logic cal_sda_drv;
  // Open-drain data line: pulled up, low when either side pulls it
  assign cal_sda_in = cal_sda_drv & (cal_sda_oen | cal_sda_out);
  logic [CAL_REGS-1:0][7:0] cal_trim;
  logic [1:0] shared_req_valid, shared_req_ready, req_read_write_sel, axi_wvalid;
  logic [1:0] axi_wready, axi_wlast, axi_bvalid, axi_bready, axi_rvalid, axi_rready, axi_rlast;
  logic [1:0][31:0] shared_req_addr;
  logic [1:0][1:0] shared_burst_type, shared_lock_type, axi_rresp;
  logic [1:0][7:0] shared_req_tag, shared_burst_len, axi_wid, axi_bid, axi_rid;
  logic [1:0][2:0] shared_beat_size;
  logic [1:0][127:0] axi_wdata, axi_rdata;
  logic [1:0][15:0] axi_wstrb;
  logic [127:0] dw = 128'h0123456789ABCDEF_FEDCBA9876543210;
  logic [127:0] de = 128'h55AA55AA55AA55AA_33CC33CC33CC33CC;
  int error_cnt = 0;
  int n_checks = 0;

  dhap_ctrl u_dhap_ctrl (.*);
  dhap_axi_master u_dhap_axi_master (.*);

  // PHY clock is a PLL output outside this block; only mclk here
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input int p, input logic [31:0] a, input logic [1:0] bt,
      input logic [7:0] t, input int n, input logic [127:0] b, input logic [15:0] s);
    logic [7:0] id;
    u_dhap_axi_master.req(p, 1'b1, a, bt, t, 8'(n - 1));
    for (int i = 0; i < n; i++) begin
      u_dhap_axi_master.wbeat(p, b + 128'(i), (i == n - 1) ? s : 16'hFFFF, i == n - 1, i);
    end
    u_dhap_axi_master.bresp(p, 2, id);
    chk(id, t);
  endtask

  task automatic rd(input int p, input logic [31:0] a, input logic [1:0] bt,
      input logic [7:0] t, input int n, input logic [1:0] rs, input logic [1:0][127:0] e);
    logic [127:0] d;
    logic [7:0] id;
    logic [1:0] r;
    logic l;
    u_dhap_axi_master.req(p, 1'b0, a, bt, t, 8'(n - 1));
    for (int i = 0; i < n; i++) begin
      u_dhap_axi_master.rbeat(p, i * 3, d, id, r, l);
      if (rs === RESP_OKAY) chk(d, e[i]);
      chk(id, t);
      chk(r, rs);
      chk(l, i == n - 1);
    end
  endtask

  task automatic start_up;
    @(negedge mclk);
    init_sequencer_go = 1'b1;
    @(negedge mclk);
    init_sequencer_go = 1'b0;
    for (int i = 0; i < 300 && init_done !== 1'b1; i++) @(negedge mclk);
    chk(shared_req_ready, 2'b11);
  endtask

  task automatic t_reset;
    chk(cal_trim, {CAL_REGS{CAL_TRIM_RESET}});
    chk(cal_sda_oen, 1'b1);
    repeat (5) @(negedge mclk);
    chk({init_done, shared_req_ready}, 3'b000);
    start_up();
  endtask

  // Incrementing burst, a partial overwrite of its second beat, then a wrapping burst
  task automatic t_incr;
    wr(0, 32'h100, BURST_INCR, 8'h3C, 2, dw, 16'hFFFF);
    wr(0, 32'h110, BURST_INCR, 8'h3D, 1, de, 16'h00FF);
    rd(0, 32'h100, BURST_INCR, 8'hA5, 2, RESP_OKAY, {{dw[127:64], de[63:0]}, dw});
    wr(0, 32'h130, BURST_WRAP, 8'h44, 2, dw, 16'hFFFF);
    rd(0, 32'h120, BURST_INCR, 8'h45, 2, RESP_OKAY, {dw, dw + 128'h1});
  endtask

  // Fixed burst on the other port lands both beats on one word
  task automatic t_fixed;
    wr(1, 32'h200, BURST_FIXED, 8'h11, 2, de, 16'hFFFF);
    rd(1, 32'h200, BURST_FIXED, 8'h22, 1, RESP_OKAY, {128'h0, de + 128'h1});
  endtask

  task automatic t_err;
    rd(0, 32'h1000, BURST_INCR, 8'h7E, 1, RESP_SLVERR, '0);
  endtask

  // One calibration bus bit; the line is sampled late in the high phase
  task automatic cal_bit(input logic b, output logic s);
    cal_sda_drv = b;
    repeat (4) @(negedge mclk);
    cal_scl_in = 1'b1;
    repeat (4) @(negedge mclk);
    s = cal_sda_in;
    cal_scl_in = 1'b0;
  endtask

  // Start or repeated start, or a stop that leaves the bus idle
  task automatic cal_cond(input logic stop);
    cal_sda_drv = ~stop;
    repeat (4) @(negedge mclk);
    cal_scl_in = 1'b1;
    repeat (4) @(negedge mclk);
    cal_sda_drv = stop;
    repeat (4) @(negedge mclk);
    cal_scl_in = stop;
  endtask

  task automatic cal_byte(input logic [7:0] v, input logic m_ack, output logic [7:0] r,
      output logic ack);
    for (int i = 7; i >= 0; i--) cal_bit(v[i], r[i]);
    cal_bit(m_ack, ack);
  endtask

  // Write one trim byte, then read it back after a repeated start
  task automatic t_cal;
    logic [7:0] r;
    logic a;
    cal_cond(1'b0);
    cal_byte({CAL_DEV_ADDR, 1'b0}, 1'b1, r, a);
    chk(a, 1'b0);
    cal_byte(8'h01, 1'b1, r, a);
    cal_byte(8'h5A, 1'b1, r, a);
    chk(a, 1'b0);
    cal_cond(1'b1);
    chk(cal_trim, {CAL_TRIM_RESET, CAL_TRIM_RESET, 8'h5A, CAL_TRIM_RESET});
    cal_cond(1'b0);
    cal_byte({CAL_DEV_ADDR, 1'b0}, 1'b1, r, a);
    cal_byte(8'h01, 1'b1, r, a);
    cal_cond(1'b0);
    cal_byte({CAL_DEV_ADDR, 1'b1}, 1'b1, r, a);
    chk(a, 1'b0);
    cal_byte(8'hFF, 1'b1, r, a);
    chk({r, a}, 9'h0B5);
    cal_cond(1'b1);
  endtask

  task automatic t_seq_reset;
    @(negedge mclk);
    init_sequencer_reset = 1'b1;
    @(negedge mclk);
    init_sequencer_reset = 1'b0;
    chk({init_done, shared_req_ready}, 3'b000);
    start_up();
    rd(1, 32'h200, BURST_INCR, 8'h33, 1, RESP_OKAY, {128'h0, de + 128'h1});
  endtask

  initial begin
    {rstn, init_sequencer_go, init_sequencer_reset} = 3'b000;
    {cal_scl_in, cal_sda_drv} = 2'b11;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    t_reset();
    t_incr();
    t_fixed();
    t_err();
    t_seq_reset();
    t_cal();
    report_and_stop();
  end

  initial begin
    #50us;
    error_cnt++;
    report_and_stop();
  end
endmodule
